// >>> rtl/sesr_buf2.sv
`timescale 1ns/1ns
`default_nettype none
module sesr_buf2 #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0]   cnt;
  } sesr_buf_st_t;

  sesr_buf_st_t r;
  sesr_buf_st_t n;
  logic         push;
  logic         pop;

  // two entries: honest full at two, empty at zero
  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data  = r.d0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pop shifts d1 down; push lands in first free slot after the pop
  always_comb begin
    n = r;
    if (pop) begin
      n.d0 = r.d1;
    end
    if (push) begin
      if ((r.cnt == 2'h0) || (r.cnt == 2'h1 && pop)) begin
        n.d0 = in_data;
      end else begin
        n.d1 = in_data;
      end
    end
    n.cnt = 2'(r.cnt + {1'b0, push} - {1'b0, pop});
    if (flush) begin
      n.cnt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sesr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module sesr_ctrl #(
  parameter int PROG_CYCLES = sesr_pkg::PROG_CYCLES,
  parameter int ADDR_W      = sesr_pkg::ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_sck,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe,
  input  wire logic              wp_n,
  output logic                   mem_req_valid,
  input  wire logic              mem_req_ready,
  output logic      [ADDR_W-1:0] mem_req_addr,
  input  wire logic              mem_rsp_valid,
  output logic                   mem_rsp_ready,
  input  wire logic [7:0]        mem_rsp_data,
  input  wire logic              array_write_done,
  input  wire logic [ADDR_W-1:0] prot_chk_addr,
  output logic                   prot_chk_hit,
  output logic                   hw_protect,
  output logic      [7:0]        status_value
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] WC_LOAD = CW'(PROG_CYCLES - 1);

  typedef struct packed {
    sesr_pkg::sesr_state_t state;
    logic              sck_d;
    logic              sel_d;
    logic [2:0]        bit_cnt;
    logic [7:0]        sh_in;
    logic [1:0]        addr_bytes;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        out_sr;
    logic              miso;
    logic              miso_oe;
    logic              need_load;
    logic              write_enable_latch;
    logic              nv_lock;
    logic [1:0]        nv_bp;
    logic              busy;
    logic [CW-1:0]     wc_cnt;
    logic [7:0]        wr_data;
    logic              req_pending;
    logic              rsp_discard;
    logic              prot_hit;
    logic              hw_prot;
  } sesr_st_t;

  sesr_st_t r;
  sesr_st_t n;

  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       mosi_s;
  logic       wp_n_s;
  logic       sel;
  logic       rise;
  logic       fall;
  logic       cs_rise;
  logic [7:0] rx_byte;
  logic [7:0] status_now;
  logic       opc_done;
  logic       status_write_cmd_ok;
  logic       req_fire;
  logic       rsp_fire;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_out_ready;
  logic [7:0] buf_out_data;

  // status byte with reserved bits forced to zero
  function automatic logic [7:0] status_pack(input logic lock,
                                             input logic [1:0] bp,
                                             input logic write_enable_latch,
                                             input logic busy);
    status_pack = {lock, sesr_pkg::RESERVED_VAL, bp, write_enable_latch, busy};
  endfunction

  // protected range per block-protect code
  function automatic logic addr_protected(input logic [1:0] bp,
                                          input logic [ADDR_W-1:0] a);
    logic [16:0] a17;
    a17 = 17'(a);
    unique case (bp)
      sesr_pkg::BP_NONE:    addr_protected = 1'b0;
      sesr_pkg::BP_QUARTER: addr_protected = (a17 >= sesr_pkg::ADDR_QUARTER);
      sesr_pkg::BP_HALF:    addr_protected = (a17 >= sesr_pkg::ADDR_HALF);
      sesr_pkg::BP_ALL:     addr_protected = 1'b1;
    endcase
  endfunction

  // next read address, wraps at the top of the array
  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = ADDR_W'(a + 1'b1);
  endfunction

  // pins come from the master's domain: two flops first
  sesr_sync #(
    .W       (4),
    .RST_VAL (4'hB)
  ) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d_in    ({spi_cs_n, spi_sck, spi_mosi, wp_n}),
    .d_out   (pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sck_s  = pins_s[2];
  assign mosi_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // edges of the sampled link clock, works for idle low or high
  assign sel     = ~cs_n_s;
  assign rise    = sck_s & ~r.sck_d;
  assign fall    = ~sck_s & r.sck_d;
  assign cs_rise = r.sel_d & ~sel;
  assign rx_byte = {r.sh_in[6:0], mosi_s};
  assign opc_done = sel && rise && (r.state == sesr_pkg::ST_OPC) &&
                    (r.bit_cnt == sesr_pkg::LAST_BIT);
  assign status_now = status_pack(r.nv_lock, r.nv_bp, r.write_enable_latch, r.busy);

  // status write allowed with latch set and not busy, unless locked with the pin low
  assign status_write_cmd_ok = r.write_enable_latch && !r.busy && (!r.nv_lock || wp_n_s);

  // read data prefetch, one request outstanding at a time
  assign mem_req_valid = sel && (r.state == sesr_pkg::ST_READ) &&
                         !r.req_pending && !r.rsp_discard;
  assign mem_req_addr  = r.addr;
  assign req_fire      = mem_req_valid & mem_req_ready;
  // a late answer after deselect is swallowed, never buffered
  assign buf_in_valid  = mem_rsp_valid & ~r.rsp_discard;
  assign mem_rsp_ready = r.rsp_discard | buf_in_ready;
  assign rsp_fire      = mem_rsp_valid & mem_rsp_ready;
  assign buf_out_ready = sel && fall && r.need_load &&
                         (r.state == sesr_pkg::ST_READ);

  // stall by the shifter leaves words here instead of losing them
  sesr_buf2 #(
    .W (8)
  ) u_buf (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .flush     (~sel),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rsp_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // command engine, write timer and status bits
  always_comb begin
    logic [7:0] obyte;
    obyte   = sesr_pkg::IDLE_BYTE;
    n       = r;
    n.sck_d = sck_s;
    n.sel_d = sel;
    n.prot_hit = addr_protected(r.nv_bp, prot_chk_addr);
    n.hw_prot  = r.nv_lock & ~wp_n_s;
    // self-timed cycle; nonvolatile bits land at its end
    if (r.busy) begin
      if (r.wc_cnt == '0) begin
        n.busy    = 1'b0;
        n.write_enable_latch     = 1'b0;
        n.nv_lock = r.wr_data[sesr_pkg::BIT_LOCK];
        n.nv_bp   = r.wr_data[sesr_pkg::BIT_BP_HI:sesr_pkg::BIT_BP_LO];
      end else begin
        n.wc_cnt = CW'(r.wc_cnt - 1'b1);
      end
    end
    if (array_write_done) begin
      n.write_enable_latch = 1'b0;
    end
    if (req_fire) begin
      n.req_pending = 1'b1;
      n.addr        = addr_inc(r.addr);
    end
    if (rsp_fire) begin
      n.req_pending = 1'b0;
      n.rsp_discard = 1'b0;
    end
    if (!sel) begin
      // deselect ends every command at any bit
      n.state      = sesr_pkg::ST_OPC;
      n.bit_cnt    = 3'h0;
      n.addr_bytes = 2'h0;
      n.miso_oe    = 1'b0;
      n.need_load  = 1'b0;
      if (cs_rise && r.state == sesr_pkg::ST_STATUS_WRITE_CMD_DONE && status_write_cmd_ok) begin
        n.busy   = 1'b1;
        n.wc_cnt = WC_LOAD;
      end
      if (cs_rise && r.req_pending && !rsp_fire) begin
        n.rsp_discard = 1'b1;
      end
    end else begin
      if (rise) begin
        n.sh_in   = rx_byte;
        n.bit_cnt = 3'(r.bit_cnt + 1'b1);
        // a clock beyond the data byte kills the status write
        if (r.state == sesr_pkg::ST_STATUS_WRITE_CMD_DONE) begin
          n.state = sesr_pkg::ST_WAIT;
        end
        if (r.bit_cnt == sesr_pkg::LAST_BIT) begin
          unique case (r.state)
            sesr_pkg::ST_OPC: begin
              if (r.busy && rx_byte != sesr_pkg::OP_STATUS_READ) begin
                n.state = sesr_pkg::ST_WAIT;
              end else begin
                unique case (rx_byte)
                  sesr_pkg::OP_STATUS_READ: begin
                    n.state     = sesr_pkg::ST_STAT;
                    n.need_load = 1'b1;
                  end
                  sesr_pkg::OP_WRITE_ENABLE: begin
                    n.write_enable_latch   = 1'b1;
                    n.state = sesr_pkg::ST_WAIT;
                  end
                  sesr_pkg::OP_WRITE_DISABLE: begin
                    n.write_enable_latch   = 1'b0;
                    n.state = sesr_pkg::ST_WAIT;
                  end
                  sesr_pkg::OP_STATUS_WRITE: begin
                    n.state = sesr_pkg::ST_STATUS_WRITE_CMD_DATA;
                  end
                  sesr_pkg::OP_ARRAY_READ: begin
                    n.state = sesr_pkg::ST_ADDR;
                  end
                  default: begin
                    n.state = sesr_pkg::ST_WAIT;
                  end
                endcase
              end
            end
            sesr_pkg::ST_ADDR: begin
              // upper address bits fall off the top of the shift
              n.addr       = {r.addr[ADDR_W-9:0], rx_byte};
              n.addr_bytes = 2'(r.addr_bytes + 1'b1);
              if (r.addr_bytes == sesr_pkg::LAST_ADDR) begin
                n.state     = sesr_pkg::ST_READ;
                n.need_load = 1'b1;
              end
            end
            sesr_pkg::ST_STAT: begin
              n.need_load = 1'b1;
            end
            sesr_pkg::ST_READ: begin
              n.need_load = 1'b1;
            end
            sesr_pkg::ST_STATUS_WRITE_CMD_DATA: begin
              n.wr_data = rx_byte;
              n.state   = sesr_pkg::ST_STATUS_WRITE_CMD_DONE;
            end
            sesr_pkg::ST_STATUS_WRITE_CMD_DONE: begin
              n.state = sesr_pkg::ST_WAIT;
            end
            sesr_pkg::ST_WAIT: begin
              n.state = sesr_pkg::ST_WAIT;
            end
            default: begin
              n.state = sesr_pkg::ST_WAIT;
            end
          endcase
        end
      end
      // output moves only after a falling edge, msb first
      if (fall && r.need_load) begin
        if (r.state == sesr_pkg::ST_STAT) begin
          obyte = status_now;
        end else if (buf_out_valid) begin
          obyte = buf_out_data;
        end
        n.miso      = obyte[7];
        n.out_sr    = {obyte[6:0], 1'b0};
        n.miso_oe   = 1'b1;
        n.need_load = 1'b0;
      end else if (fall && r.miso_oe) begin
        n.miso   = r.out_sr[7];
        n.out_sr = {r.out_sr[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r         <= '0;
      r.state   <= sesr_pkg::ST_OPC;
      r.sck_d   <= 1'b0; // same as the synchroniser's clock reset level
      r.nv_lock <= sesr_pkg::LOCK_RST;
      r.nv_bp   <= sesr_pkg::BP_RST;
      r.write_enable_latch     <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign spi_miso     = r.miso;
  assign spi_miso_oe  = r.miso_oe;
  assign prot_chk_hit = r.prot_hit;
  assign hw_protect   = r.hw_prot;
  assign status_value = status_now;

  // helper: length of the busy run
  int busy_run;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      busy_run <= 0;
    end else begin
      busy_run <= r.busy ? busy_run + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_reserved_zero: assert property (
    opc_done && rx_byte == sesr_pkg::OP_STATUS_READ
    |-> status_value[6:4] == 3'h0)
    else $error("reserved status bits not zero");

  a_busy_length: assert property (
    $fell(r.busy) |-> busy_run == PROG_CYCLES)
    else $error("write cycle length wrong");

  a_wel_end_clear: assert property (
    $fell(r.busy) |-> !r.write_enable_latch && status_value[sesr_pkg::BIT_BUSY] == 1'b0)
    else $error("latch not cleared at end of write cycle");

  a_nv_only_end: assert property (
    ($changed(r.nv_bp) || $changed(r.nv_lock)) |-> $past(r.busy) && !r.busy)
    else $error("protect bits changed outside write cycle end");

  a_locked_refuse: assert property (
    (cs_rise && r.state == sesr_pkg::ST_STATUS_WRITE_CMD_DONE && r.nv_lock && !wp_n_s)
    |=> !r.busy)
    else $error("locked status write was accepted");

  a_no_wel_ignore: assert property (
    (cs_rise && r.state == sesr_pkg::ST_STATUS_WRITE_CMD_DONE && !r.write_enable_latch && !r.busy)
    |=> !r.busy)
    else $error("status write without latch started a cycle");

  a_status_write_cmd_start: assert property (
    (cs_rise && r.state == sesr_pkg::ST_STATUS_WRITE_CMD_DONE && status_write_cmd_ok)
    |=> r.busy && r.wc_cnt == WC_LOAD)
    else $error("valid status write did not start cycle");

  a_write_enable_cmd_sets: assert property (
    (opc_done && !r.busy && rx_byte == sesr_pkg::OP_WRITE_ENABLE)
    |=> r.write_enable_latch && r.state == sesr_pkg::ST_WAIT)
    else $error("write enable did not set latch");

  a_write_disable_cmd_clears: assert property (
    (opc_done && !r.busy && rx_byte == sesr_pkg::OP_WRITE_DISABLE)
    |=> !r.write_enable_latch && r.state == sesr_pkg::ST_WAIT)
    else $error("write disable did not clear latch");

  a_busy_blocks: assert property (
    (opc_done && r.busy && rx_byte != sesr_pkg::OP_STATUS_READ)
    |=> r.state == sesr_pkg::ST_WAIT ##1 !mem_req_valid)
    else $error("opcode executed while busy");

  a_addr_wrap: assert property (
    (req_fire && r.addr == {ADDR_W{1'b1}}) |=> r.addr == '0)
    else $error("read address did not wrap");

  c_status_poll: cover property (
    opc_done && r.busy && rx_byte == sesr_pkg::OP_STATUS_READ);
  c_status_write_cmd_cycle: cover property ($fell(r.busy));
  c_read_stream: cover property (req_fire ##[1:200] req_fire);
endmodule
`default_nettype wire

// >>> rtl/sesr_pkg.sv
// Function
// - one 8-bit status byte: lock bit7, protect bits3:2, latch bit1, busy bit0.
// - status bits 6 to 4 always read back as zero.
// - protect code 00 none, 01 upper quarter, 10 upper half, 11 all.
// - writes into the protected address range are refused.
// - enable latch reads 1 when writes enabled, cleared at power-up.
// - busy flag reads 1 during the self-timed write, else 0.
// - opcode 05h streams the live status byte while chip select stays low.
// - status read works anytime, even while busy; deselect ends it.
// - opcode 06h sets the enable latch, then input ignored until deselect.
// - opcode 04h clears the enable latch, then waits for deselect.
// - latch cleared at power-up, disable command, and any write completion.
// - status write is 01h plus one byte; deselect exactly after bit eight.
// - valid status write starts fixed busy cycle, latch cleared at end.
// - status write changes only lock and protect bits.
// - status write accepted when lock bit is 0 or protect pin high.
// - lock bit set with protect pin low refuses every status write.
// - hardware protection starts on whichever comes second; pin high ends it.
// - opcode 03h plus three address bytes; low 17 bits select the byte.
// - read address increments per byte and wraps from top to zero.
// - deselect at any bit ends an array read without side effects.
// - array read neither accepted nor executed while busy.
// - input sampled on clock rise, output changes after clock fall.
// - most significant bit first; each command starts at select falling.
// - unknown opcode makes the device ignore input until deselect.
// - while busy only the status read opcode is executed.
`default_nettype none
package sesr_pkg;
  // clock and self-timed write cycle
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 1000000;
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // array geometry
  localparam int ADDR_W = 17;
  localparam logic [16:0] ADDR_QUARTER = 17'h18000;
  localparam logic [16:0] ADDR_HALF    = 17'h10000;
  // opcodes
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
  // status field positions
  localparam int BIT_LOCK  = 7;
  localparam int BIT_BP_HI = 3;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_WEL   = 1;
  localparam int BIT_BUSY  = 0;
  localparam logic [2:0] RESERVED_VAL = 3'h0;
  // protect codes and delivered values
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;
  localparam logic [1:0] BP_RST     = 2'h0;
  localparam logic       LOCK_RST   = 1'h0;
  localparam logic [7:0] IDLE_BYTE  = 8'hFF;
  // bit counter end of byte
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] LAST_ADDR  = 2'h2;

  typedef enum logic [2:0] {
    ST_OPC       = 3'b000,
    ST_ADDR      = 3'b001,
    ST_STAT      = 3'b010,
    ST_READ      = 3'b011,
    ST_STATUS_WRITE_CMD_DATA = 3'b100,
    ST_STATUS_WRITE_CMD_DONE = 3'b101,
    ST_WAIT      = 3'b110
  } sesr_state_t;
endpackage
`default_nettype wire

// >>> rtl/sesr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sesr_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sesr_sync_st_t;

  sesr_sync_st_t r;
  sesr_sync_st_t n;

  // first stage is only read by the second stage
  always_comb begin
    n    = r;
    n.s1 = d_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign d_out = r.s2;
endmodule
`default_nettype wire

// >>> tb/sesr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sesr_host_model (
  input  wire logic sys_clk,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_mosi = 1'b1;
  end
  // wait n system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // mode 0 byte, four clocks per level so the device syncs see each one
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin // msb first
      spi_sck  <= 1'b0;
      spi_mosi <= tx[i];
      hold(4);
      spi_sck <= 1'b1; // data set while low, taken on rise
      hold(4);
      rx[i] = spi_miso; // settled since the last fall
    end
  endtask
  // every command opens with a select fall
  task automatic cmd_start();
    spi_cs_n <= 1'b0;
    hold(4);
  endtask
  // deselect while clock still high, before any further rise
  task automatic cmd_end();
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line must not keep stale data
    hold(2);
    spi_sck <= 1'b0;
    hold(4);
  endtask
endmodule
`default_nettype wire

// >>> tb/spi_eeprom_status_read_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_status_read_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        resetn, wp_n, array_write_done, mem_rsp_valid;
  logic        spi_cs_n, spi_sck, spi_mosi, spi_miso, mem_req_valid;
  logic        mem_rsp_ready, prot_chk_hit, hw_protect, exp_hit;
  logic        spi_miso_oe;
  logic        mem_req_ready = 1'b1;
  logic        saw_full = 1'b0;
  logic [16:0] mem_req_addr, prot_chk_addr;
  logic [16:0] pa [4] = '{17'h0FFFF, 17'h10000, 17'h17FFF, 17'h18000};
  logic [7:0]  mem_rsp_data, rx, status_value;
  int          n_errors, num_checks;

  always #50 sys_clk = ~sys_clk;

  // long enough that commands fit inside one busy cycle
  sesr_ctrl #(.PROG_CYCLES(1000)) sesr_ctrl_i (
    .sys_clk(sys_clk), .resetn(resetn), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .wp_n(wp_n), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_ready(mem_rsp_ready),
    .mem_rsp_data(mem_rsp_data), .array_write_done(array_write_done),
    .prot_chk_addr(prot_chk_addr), .prot_chk_hit(prot_chk_hit),
    .hw_protect(hw_protect), .status_value(status_value)
  );
  sesr_host_model sesr_host_model_i (
    .sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  // array content is a function of the address, so any slip shows
  function automatic logic [7:0] memf(input logic [16:0] a);
    return a[7:0] ^ 8'h5A ^ {a[16], 7'h00};
  endfunction
  // one outstanding request; response holds until taken
  always @(posedge sys_clk) begin
    if (!resetn) begin
      mem_rsp_valid <= 1'b0;
    end else if (mem_req_valid && mem_req_ready) begin
      mem_rsp_valid <= 1'b1;
      mem_rsp_data  <= memf(mem_req_addr);
    end else if (mem_rsp_valid && mem_rsp_ready) begin
      mem_rsp_valid <= 1'b0;
    end
    if (mem_rsp_valid && !mem_rsp_ready) saw_full <= 1'b1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic spi_cmd(input logic [7:0] op, input logic [7:0] d,
                         input int n, output logic [7:0] r);
    sesr_host_model_i.cmd_start();
    sesr_host_model_i.xfer(op, r);
    if (n > 0) sesr_host_model_i.xfer(d, r);
    sesr_host_model_i.cmd_end();
  endtask
  task automatic rd_status(output logic [7:0] r);
    spi_cmd(sesr_pkg::OP_STATUS_READ, 8'hFF, 1, r);
  endtask
  // poll busy before anything else goes out
  task automatic wr_status(input logic [7:0] v, output logic [7:0] st);
    st = 8'hFF;
    for (int k = 0; k < 20 && st[0] !== 1'b0; k++) rd_status(st);
    spi_cmd(sesr_pkg::OP_WRITE_ENABLE, 8'h00, 0, st);
    spi_cmd(sesr_pkg::OP_STATUS_WRITE, v, 1, st);
    st = 8'hFF;
    for (int k = 0; k < 20 && st[0] !== 1'b0; k++) rd_status(st);
  endtask

  // watchdog, far beyond the roughly twelve thousand clocks the tests need
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    n_errors = 0;
    num_checks = 0;
    resetn = 1'b0;
    wp_n = 1'b1;
    array_write_done = 1'b0;
    prot_chk_addr = 17'h00000;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(status_value, 8'h00);
    // delivered state, streamed twice in one select
    sesr_host_model_i.cmd_start();
    sesr_host_model_i.xfer(sesr_pkg::OP_STATUS_READ, rx);
    sesr_host_model_i.xfer(8'hFF, rx);
    check(rx, 8'h00);
    sesr_host_model_i.xfer(8'hFF, rx);
    check(rx, 8'h00);
    check({7'h00, spi_miso_oe}, 8'h01);
    sesr_host_model_i.cmd_end();
    check({7'h00, spi_miso_oe}, 8'h00);
    $display("test reset state done");
    // latch set, cleared by command and by external write completion
    spi_cmd(sesr_pkg::OP_WRITE_ENABLE, 8'h00, 0, rx);
    rd_status(rx);
    check(rx, 8'h02);
    spi_cmd(sesr_pkg::OP_WRITE_DISABLE, 8'h00, 0, rx);
    rd_status(rx);
    check(rx, 8'h00);
    spi_cmd(sesr_pkg::OP_WRITE_ENABLE, 8'h00, 0, rx);
    array_write_done <= 1'b1;
    @(posedge sys_clk);
    array_write_done <= 1'b0;
    rd_status(rx);
    check(rx, 8'h00);
    // unknown opcode swallows the rest; write without latch ignored
    sesr_host_model_i.cmd_start();
    sesr_host_model_i.xfer(8'hAB, rx);
    sesr_host_model_i.xfer(sesr_pkg::OP_WRITE_ENABLE, rx);
    sesr_host_model_i.cmd_end();
    spi_cmd(sesr_pkg::OP_STATUS_WRITE, 8'h8C, 1, rx);
    rd_status(rx);
    check(rx, 8'h00);
    $display("test latch done");
    // status write: busy visible, only lock and protect bits change
    spi_cmd(sesr_pkg::OP_WRITE_ENABLE, 8'h00, 0, rx);
    spi_cmd(sesr_pkg::OP_STATUS_WRITE, 8'hFF, 1, rx);
    rd_status(rx);
    check(rx, 8'h03);
    // while busy a read never drives out and a disable is ignored
    sesr_host_model_i.cmd_start();
    for (int b = 0; b < 5; b++)
      sesr_host_model_i.xfer(sesr_pkg::OP_ARRAY_READ, rx);
    check({7'h00, spi_miso_oe}, 8'h00);
    sesr_host_model_i.cmd_end();
    spi_cmd(sesr_pkg::OP_WRITE_DISABLE, 8'h00, 0, rx);
    rd_status(rx);
    check(rx, 8'h03);
    wr_status(8'hFF, rx);
    check(rx, 8'h8C);
    // lock with pin low refuses writes until the pin goes high
    wp_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({7'h00, hw_protect}, 8'h01);
    wr_status(8'h00, rx);
    check(rx, 8'h8E);
    wp_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({7'h00, hw_protect}, 8'h00);
    wr_status(8'h00, rx);
    check(rx, 8'h00);
    $display("test status write done");
    // every protect code against the range boundaries
    for (int c = 0; c < 4; c++) begin
      wr_status({4'h0, c[1:0], 2'b00}, rx);
      check(rx, {4'h0, c[1:0], 2'b00});
      for (int j = 0; j < 4; j++) begin
        prot_chk_addr <= pa[j];
        repeat (3) @(posedge sys_clk);
        exp_hit = (c == 3) || (c == 2 && pa[j] >= 17'h10000)
                  || (c == 1 && pa[j] >= 17'h18000);
        check({7'h00, prot_chk_hit}, {7'h00, exp_hit});
      end
    end
    $display("test protect codes done");
    // read across the top, upper address bits set
    sesr_host_model_i.cmd_start();
    sesr_host_model_i.xfer(sesr_pkg::OP_ARRAY_READ, rx);
    sesr_host_model_i.xfer(8'hFF, rx);
    sesr_host_model_i.xfer(8'hFF, rx);
    sesr_host_model_i.xfer(8'hFE, rx);
    sesr_host_model_i.hold(8);
    sesr_host_model_i.xfer(8'h00, rx);
    check(rx, memf(17'h1FFFE));
    sesr_host_model_i.xfer(8'h00, rx);
    check(rx, memf(17'h1FFFF));
    sesr_host_model_i.xfer(8'h00, rx);
    check(rx, memf(17'h00000));
    sesr_host_model_i.cmd_end();
    check({7'h00, saw_full}, 8'h01);
    rd_status(rx);
    check(rx, 8'h0C);
    check(status_value, 8'h0C);
    $display("test array read done");
    complete_run();
  end
endmodule
`default_nettype wire
